// >>> rtl/dlicr_pkg.sv
// Summary of operation
// - check generation on back channel follows enable bit
// - idle inputs pulled down when bit set, else up
// - one lane: reject sync pulses under two pixel clocks
// - two lanes: reject under four; bypass when disabled
// - forward matching transactions when match bit set
// - auto-ack writes regardless of forward lock
// - protected serializer: always gate pixels by valid
// - plain serializer: gate only when bit set
// - abort control transaction after timeout in 2 ms units
// - watchdog off when disable bit is one
// - forward every transaction when forward-all set
// - hold internal data line in 50 ns steps
// - reject clock/data glitches up to depth times 5 ns
package dlicr_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_NS = 4;
  localparam int NS_PER_MS = 1_000_000;
  localparam int WDOG_UNIT_MS = 2;
  localparam int WDOG_UNIT_CYC = WDOG_UNIT_MS * NS_PER_MS / CLK_NS;
  localparam int HOLD_STEP_NS = 50;
  localparam int HOLD_STEP_CYC = (HOLD_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GLITCH_UNIT_NS = 5;
  localparam int SYNC_FILT_ONE_LANE = 2;
  localparam int SYNC_FILT_TWO_LANE = 4;
  localparam int FILT_CW = 8;
  // ****************************************
  // register map (index, byte address = 4 x index)
  // ****************************************
  localparam logic [7:0] IDX_GEN_CFG1 = 8'h03;
  localparam logic [7:0] IDX_CC_WDOG = 8'h04;
  localparam logic [7:0] IDX_I2C_CTL1 = 8'h05;
  localparam logic [7:0] RST_GEN_CFG1 = 8'hf0;
  localparam logic [7:0] RST_CC_WDOG = 8'hfe;
  localparam logic [7:0] RST_I2C_CTL1 = 8'h1e;
  // ****************************************
  // field positions
  // ****************************************
  localparam int B_CHECK_GEN = 6;
  localparam int B_PULL_DOWN = 5;
  localparam int B_SYNC_FILT = 4;
  localparam int B_FWD_MATCH = 3;
  localparam int B_AUTO_ACK = 2;
  localparam int B_PIX_GATE = 1;
  localparam int B_TIMEOUT_LSB = 1;
  localparam int B_TIMEOUT_OFF = 0;
  localparam int B_FWD_ALL = 7;
  localparam int B_HOLD_LSB = 4;
  localparam int B_DEPTH_LSB = 0;
  localparam int TIMEOUT_W = 7;
  localparam int HOLD_W = 3;
  localparam int DEPTH_W = 4;
endpackage

// >>> rtl/dlicr_deglitch.sv
`timescale 1ns/10ps
`default_nettype none
module dlicr_deglitch
  import dlicr_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // filter control
  input wire logic count_en_in,
  input wire logic [FILT_CW-1:0] limit_in,
  // signal
  input wire logic sig_in,
  output logic sig_out
);
  logic [FILT_CW-1:0] cnt_q;
  logic out_q;
  wire differs = sig_in != out_q;
  wire [FILT_CW-1:0] cnt_inc = cnt_q + FILT_CW'(1);
  // a level is taken only once it held for limit counts
  wire accept = differs && count_en_in && (cnt_inc >= limit_in);

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (!differs || accept) begin
      cnt_q <= '0;
      out_q <= differs ? sig_in : out_q;
    end else if (count_en_in) begin
      cnt_q <= cnt_inc;
    end
  end

  assign sig_out = out_q;
endmodule
`default_nettype wire

// >>> rtl/dlicr_watchdog.sv
`timescale 1ns/10ps
`default_nettype none
module dlicr_watchdog
  import dlicr_pkg::*;
#(
  parameter int UNIT_CYCLES = WDOG_UNIT_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // control
  input wire logic disable_in,
  input wire logic [TIMEOUT_W-1:0] timeout_in,
  // transaction
  input wire logic active_in,
  output logic abort_out
);
  localparam int DW = $clog2(UNIT_CYCLES + 1);
  if (UNIT_CYCLES < 1) begin : g_bad_unit
    $error("unit must be at least one cycle");
  end

  logic [DW-1:0] div_q;
  logic [TIMEOUT_W-1:0] units_q;
  logic fired_q;
  logic abort_q;
  wire run = active_in && !disable_in && !fired_q;
  // divider restarts per transaction so the first unit is whole
  wire tick = run && (div_q == DW'(UNIT_CYCLES - 1));
  wire [TIMEOUT_W-1:0] units_inc = units_q + TIMEOUT_W'(1);
  // a zero timeout aborts at the first unit
  wire expire = tick && (units_inc >= timeout_in);

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_q <= '0;
      units_q <= '0;
      fired_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      div_q <= (!run || tick) ? '0 : div_q + DW'(1);
      units_q <= (!run || expire) ? '0 : (tick ? units_inc : units_q);
      fired_q <= active_in && (fired_q || expire);
      abort_q <= expire;
    end
  end

  assign abort_out = abort_q;
endmodule
`default_nettype wire

// >>> rtl/dlicr_top.sv
// Chosen here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module dlicr_top
  import dlicr_pkg::*;
#(
  parameter int APB_AW = 8,
  parameter int PIX_W = 24,
  parameter int WDOG_UNIT_CYCLES = WDOG_UNIT_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // static controls
  output logic back_link_check_gen_en_out,
  output logic idle_input_pull_down_out,
  // video timing pins and pixel path
  input wire logic pclk_en_in,
  input wire logic dual_lane_in,
  input wire logic pixel_valid_in,
  input wire logic line_sync_in,
  input wire logic frame_sync_in,
  input wire logic [PIX_W-1:0] pixel_data_in,
  input wire logic ser_protected_in,
  output logic pixel_valid_out,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic [PIX_W-1:0] pixel_data_out,
  // i2c pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_clean_out,
  output logic sda_held_out,
  // i2c transaction steering
  input wire logic i2c_txn_start_in,
  input wire logic i2c_addr_match_in,
  input wire logic i2c_write_in,
  input wire logic fwd_lock_in,
  output logic i2c_forward_out,
  output logic i2c_write_ack_out,
  // bidir_control_channel watchdog
  input wire logic cc_txn_active_in,
  output logic cc_txn_abort_out
);
  // ****************************************
  // elaboration checks
  // ****************************************
  // the map reaches byte address 0x14, so five address bits at least
  if (APB_AW < 5) begin : g_bad_aw
    $error("address too narrow for register map");
  end
  if (PIX_W < 1) begin : g_bad_pix
    $error("pixel width must be positive");
  end
  if (WDOG_UNIT_CYCLES < 1) begin : g_bad_unit
    $error("watchdog unit must be one cycle or more");
  end
  localparam int TOP_TIMEOUT = B_TIMEOUT_LSB + TIMEOUT_W;
  localparam int TOP_HOLD = B_HOLD_LSB + HOLD_W;
  if (TOP_TIMEOUT > 8 || TOP_HOLD > 8) begin : g_bad_field
    $error("field runs past its register byte");
  end

  // counters must hold the widest glitch and the longest hold;
  // a faster clock needs them wider
  localparam int HCW = 8;
  localparam int MAX_DEPTH_NS =
    (2 ** DEPTH_W - 1) * GLITCH_UNIT_NS + CLK_NS - 1;
  localparam int MAX_HOLD_LOAD = (2 ** HOLD_W - 1) * HOLD_STEP_CYC;
  if (MAX_DEPTH_NS >= 2 ** FILT_CW) begin : g_bad_filt
    $error("glitch width overflows filter counter");
  end
  if (SYNC_FILT_TWO_LANE >= 2 ** FILT_CW) begin : g_bad_sync
    $error("sync limit overflows filter counter");
  end
  if (MAX_HOLD_LOAD >= 2 ** HCW) begin : g_bad_hold
    $error("hold overflows hold counter");
  end

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] gen_cfg1_q;
  logic [7:0] cc_wdog_q;
  logic [7:0] i2c_ctl1_q;
  logic [31:0] prdata_q;

  function automatic logic hit(input logic [APB_AW-1:0] a,
                               input logic [7:0] idx);
    hit = (a == APB_AW'({idx, 2'b00}));
  endfunction

  wire sel_cfg1 = hit(paddr_in, IDX_GEN_CFG1);
  wire sel_wdog = hit(paddr_in, IDX_CC_WDOG);
  wire sel_ctl1 = hit(paddr_in, IDX_I2C_CTL1);
  wire mapped = sel_cfg1 || sel_wdog || sel_ctl1;
  wire access = psel_in && penable_in;
  wire setup = psel_in && !penable_in;
  // only byte lane 0 carries register bits
  wire wr_lane0 = access && pwrite_in && pstrb_in[0];
  wire [7:0] wbyte = pwdata_in[7:0];
  wire [7:0] rd_mux = sel_cfg1 ? gen_cfg1_q :
                      sel_wdog ? cc_wdog_q :
                      sel_ctl1 ? i2c_ctl1_q : 8'h00;

  // whole bytes kept so reserved bits read back as written
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gen_cfg1_q <= RST_GEN_CFG1;
      cc_wdog_q <= RST_CC_WDOG;
      i2c_ctl1_q <= RST_I2C_CTL1;
    end else begin
      if (wr_lane0 && sel_cfg1) gen_cfg1_q <= wbyte;
      if (wr_lane0 && sel_wdog) cc_wdog_q <= wbyte;
      if (wr_lane0 && sel_ctl1) i2c_ctl1_q <= wbyte;
    end
  end

  // read data captured in setup so the access phase needs no wait
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= {24'h00_0000, rd_mux};
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = access && !mapped;

  // ****************************************
  // field decode
  // ****************************************
  wire check_gen_en = gen_cfg1_q[B_CHECK_GEN];
  wire pull_down = gen_cfg1_q[B_PULL_DOWN];
  wire sync_filt_en = gen_cfg1_q[B_SYNC_FILT];
  wire fwd_match_en = gen_cfg1_q[B_FWD_MATCH];
  wire auto_ack_en = gen_cfg1_q[B_AUTO_ACK];
  wire pixel_gate_by_valid = gen_cfg1_q[B_PIX_GATE];
  wire [TIMEOUT_W-1:0] ctrl_channel_timeout =
    cc_wdog_q[B_TIMEOUT_LSB +: TIMEOUT_W];
  wire ctrl_channel_timeout_off = cc_wdog_q[B_TIMEOUT_OFF];
  wire fwd_all_en = i2c_ctl1_q[B_FWD_ALL];
  wire [HOLD_W-1:0] sda_hold = i2c_ctl1_q[B_HOLD_LSB +: HOLD_W];
  wire [DEPTH_W-1:0] glitch_depth = i2c_ctl1_q[B_DEPTH_LSB +: DEPTH_W];

  assign back_link_check_gen_en_out = check_gen_en;
  assign idle_input_pull_down_out = pull_down;

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NPIN = 5;
  wire [NPIN-1:0] pin_raw = {sda_in, scl_in, frame_sync_in,
                             line_sync_in, pixel_valid_in};
  logic [NPIN-1:0] pin_clean;

  // a change counts only once the second and third flops agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic v_q;
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          v_q <= 1'b0;
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) v_q <= s3_q;
        end
      end
      assign pin_clean[gi] = v_q;
    end
  endgenerate

  // ****************************************
  // sync pulse filter
  // ****************************************
  // counts run on pixel clock enables, so the width is in whole
  // pixel clocks; the first partial clock is credited as a whole one
  wire [FILT_CW-1:0] sync_limit = dual_lane_in ?
    FILT_CW'(SYNC_FILT_TWO_LANE) : FILT_CW'(SYNC_FILT_ONE_LANE);
  logic [2:0] sync_filt;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_vfilt
      dlicr_deglitch u_filt (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .count_en_in(pclk_en_in),
        .limit_in(sync_limit),
        .sig_in(pin_clean[gi]),
        .sig_out(sync_filt[gi])
      );
    end
  endgenerate

  wire [2:0] sync_sel = sync_filt_en ? sync_filt : pin_clean[2:0];

  // ****************************************
  // pixel gating
  // ****************************************
  // a protected pairing gates always, the bit only matters otherwise
  wire gate_on = ser_protected_in || pixel_gate_by_valid;
  wire [PIX_W-1:0] pix_next = (gate_on && !sync_sel[0]) ?
    '0 : pixel_data_in;

  logic [PIX_W-1:0] pix_q;
  logic [2:0] sync_q;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pix_q <= '0;
      sync_q <= 3'b000;
    end else begin
      pix_q <= pix_next;
      sync_q <= sync_sel;
    end
  end

  assign pixel_data_out = pix_q;
  assign pixel_valid_out = sync_q[0];
  assign line_sync_out = sync_q[1];
  assign frame_sync_out = sync_q[2];

  // ****************************************
  // i2c glitch filter
  // ****************************************
  // widths up to depth x 5 ns are rejected, so one cycle more passes
  wire [FILT_CW-1:0] depth_ns =
    FILT_CW'(glitch_depth) * FILT_CW'(GLITCH_UNIT_NS);
  wire [FILT_CW-1:0] depth_cyc =
    (depth_ns + FILT_CW'(CLK_NS - 1)) / FILT_CW'(CLK_NS);
  wire [FILT_CW-1:0] i2c_limit = depth_cyc + FILT_CW'(1);
  logic scl_f;
  logic sda_f;

  dlicr_deglitch u_scl_filt (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .count_en_in(1'b1),
    .limit_in(i2c_limit),
    .sig_in(pin_clean[3]),
    .sig_out(scl_f)
  );

  dlicr_deglitch u_sda_filt (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .count_en_in(1'b1),
    .limit_in(i2c_limit),
    .sig_in(pin_clean[4]),
    .sig_out(sda_f)
  );

  // ****************************************
  // internal sda hold
  // ****************************************
  // after scl falls the sampled sda keeps its old value for the
  // programmed hold, hiding a data change that races the clock
  logic scl_d_q;
  logic sda_hold_q;
  logic [HCW-1:0] hold_cnt_q;
  wire scl_fall = scl_d_q && !scl_f;
  wire [HCW-1:0] hold_load =
    HCW'(sda_hold) * HCW'(HOLD_STEP_CYC);
  wire holding = hold_cnt_q != '0;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_d_q <= 1'b0;
      sda_hold_q <= 1'b0;
      hold_cnt_q <= '0;
    end else begin
      scl_d_q <= scl_f;
      if (scl_fall) begin
        hold_cnt_q <= hold_load;
      end else if (holding) begin
        hold_cnt_q <= hold_cnt_q - HCW'(1);
      end
      if (!holding && !scl_fall) sda_hold_q <= sda_f;
    end
  end

  assign scl_clean_out = scl_d_q;
  assign sda_held_out = sda_hold_q;

  // ****************************************
  // transaction steering
  // ****************************************
  wire fwd_decide = fwd_all_en || (fwd_match_en && i2c_addr_match_in);
  // normal acknowledgement needs forward lock
  wire ack_decide = i2c_write_in && (auto_ack_en || fwd_lock_in);

  logic fwd_q;
  logic ack_q;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fwd_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (i2c_txn_start_in) begin
      fwd_q <= fwd_decide;
      ack_q <= ack_decide;
    end
  end

  assign i2c_forward_out = fwd_q;
  assign i2c_write_ack_out = ack_q;

  // ****************************************
  // control channel watchdog
  // ****************************************
  dlicr_watchdog #(
    .UNIT_CYCLES(WDOG_UNIT_CYCLES)
  ) u_wdog (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .disable_in(ctrl_channel_timeout_off),
    .timeout_in(ctrl_channel_timeout),
    .active_in(cc_txn_active_in),
    .abort_out(cc_txn_abort_out)
  );
endmodule
`default_nettype wire

// >>> verification/dlicr_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dlicr_properties
  import dlicr_pkg::*;
#(
  parameter int APB_AW = 8,
  parameter int PIX_W = 24,
  parameter int WDOG_UNIT_CYCLES = WDOG_UNIT_CYC
) (
  // clock, reset, apb
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  // controls and pixel path
  input wire logic back_link_check_gen_en_out,
  input wire logic idle_input_pull_down_out,
  input wire logic ser_protected_in,
  input wire logic pixel_valid_out,
  input wire logic [PIX_W-1:0] pixel_data_in,
  input wire logic [PIX_W-1:0] pixel_data_out,
  // steering and watchdog
  input wire logic i2c_txn_start_in,
  input wire logic i2c_addr_match_in,
  input wire logic i2c_write_in,
  input wire logic fwd_lock_in,
  input wire logic i2c_forward_out,
  input wire logic i2c_write_ack_out,
  input wire logic cc_txn_active_in,
  input wire logic cc_txn_abort_out
);
  // ****
  // shadow registers
  // ****
  logic [7:0] s3_q;
  logic [7:0] s4_q;
  logic [7:0] s5_q;
  logic [31:0] cnt_q;
  logic fired_q;
  wire a3 = paddr_in == APB_AW'({IDX_GEN_CFG1, 2'b00});
  wire a4 = paddr_in == APB_AW'({IDX_CC_WDOG, 2'b00});
  wire a5 = paddr_in == APB_AW'({IDX_I2C_CTL1, 2'b00});
  wire wr = psel_in & penable_in & pwrite_in & pstrb_in[0];
  wire [7:0] rdv = a3 ? s3_q : a4 ? s4_q : a5 ? s5_q : 8'h00;
  wire g = ser_protected_in | s3_q[B_PIX_GATE];
  wire [6:0] tmo = s4_q[7:1];
  // a zero timeout still waits one unit
  wire [31:0] lim = WDOG_UNIT_CYCLES * (tmo == 7'h0 ? 1 : 32'(tmo));
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s3_q <= RST_GEN_CFG1;
      s4_q <= RST_CC_WDOG;
      s5_q <= RST_I2C_CTL1;
    end else if (wr) begin
      if (a3) s3_q <= pwdata_in[7:0];
      if (a4) s4_q <= pwdata_in[7:0];
      if (a5) s5_q <= pwdata_in[7:0];
    end
  end
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
    end else begin
      cnt_q <= (cc_txn_active_in && !s4_q[0]) ? cnt_q + 1 : '0;
      fired_q <= cc_txn_active_in && (fired_q || cc_txn_abort_out);
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  chk_check_gen: assert property (
    back_link_check_gen_en_out == s3_q[B_CHECK_GEN]) else $error("crc en");
  chk_pull_dir: assert property (
    idle_input_pull_down_out == s3_q[B_PULL_DOWN]) else $error("pull");
  chk_read_data: assert property (
    psel_in && !penable_in && !pwrite_in |=> prdata_out == {24'h0, $past(rdv)})
    else $error("read data");
  chk_fwd_decide: assert property (i2c_txn_start_in |=>
    i2c_forward_out == ($past(s5_q[B_FWD_ALL]) |
    ($past(s3_q[B_FWD_MATCH]) & $past(i2c_addr_match_in)))) else $error("fwd");
  chk_ack_decide: assert property (i2c_txn_start_in |=>
    i2c_write_ack_out == ($past(i2c_write_in) &
    ($past(s3_q[B_AUTO_ACK]) | $past(fwd_lock_in)))) else $error("ack");
  chk_gate_zero: assert property (
    $past(g) && !pixel_valid_out && !$past(pixel_valid_out) |->
    pixel_data_out == '0) else $error("gate");
  chk_gate_pass: assert property (
    !$past(g) |-> pixel_data_out == $past(pixel_data_in)) else $error("pass");
  chk_gate_valid: assert property (
    $past(g) && pixel_valid_out |-> pixel_data_out == $past(pixel_data_in))
    else $error("valid data");
  chk_abort_window: assert property (
    cc_txn_abort_out |-> cnt_q + 1 >= lim && cnt_q <= lim + 2)
    else $error("abort early");
  chk_abort_bound: assert property (
    cnt_q == lim + 3 |-> fired_q) else $error("abort late");
  chk_wdog_off: assert property (
    s4_q[0] && $past(s4_q[0]) |-> !cc_txn_abort_out) else $error("wdog off");
  cover property (cc_txn_abort_out);
  cover property (i2c_txn_start_in && i2c_addr_match_in);
  cover property (wr && a4);
endmodule
bind dlicr_top dlicr_properties #(.APB_AW(APB_AW), .PIX_W(PIX_W),
  .WDOG_UNIT_CYCLES(WDOG_UNIT_CYCLES)) u_props (.clock_in, .resetn_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
  .prdata_out, .back_link_check_gen_en_out, .idle_input_pull_down_out,
  .ser_protected_in, .pixel_valid_out, .pixel_data_in, .pixel_data_out,
  .i2c_txn_start_in, .i2c_addr_match_in, .i2c_write_in, .fwd_lock_in,
  .i2c_forward_out, .i2c_write_ack_out, .cc_txn_active_in, .cc_txn_abort_out);
`default_nettype wire

// >>> verification/dlicr_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module dlicr_far_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // request: len 0 never completes
  input wire logic go_in,
  input wire logic [7:0] len_in,
  // toward the block
  output logic pclk_en_out,
  output logic active_out
);
  logic [7:0] left_q;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pclk_en_out <= 1'b0;
      active_out <= 1'b0;
      left_q <= 8'h00;
    end else begin
      pclk_en_out <= !pclk_en_out;
      if (go_in) begin
        active_out <= 1'b1;
        left_q <= len_in;
      end else if (left_q == 8'h01) begin
        active_out <= 1'b0;
        left_q <= 8'h00;
      end else if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_deser_link_i2c_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_deser_link_i2c_config_regs;
  import dlicr_pkg::*;
  logic clock_in = 1'b0, resetn_in = 1'b0, go = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00, lent = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'h1;
  logic dual_lane_in = 1'b0, pixel_valid_in = 1'b0, ser_protected_in = 1'b0;
  logic [23:0] pixel_data_in = 24'h0;
  logic line_sync_in = 1'b0, frame_sync_in = 1'b0;
  logic scl_in = 1'b1, sda_in = 1'b1, scl_clean_out, sda_held_out;
  logic line_sync_out, frame_sync_out;
  logic i2c_txn_start_in = 1'b0, i2c_addr_match_in = 1'b0;
  logic i2c_write_in = 1'b0, fwd_lock_in = 1'b0;
  logic pclk_en_in, cc_txn_active_in, pready_out, pslverr_out;
  logic back_link_check_gen_en_out, idle_input_pull_down_out;
  logic pixel_valid_out, i2c_forward_out, i2c_write_ack_out, cc_txn_abort_out;
  logic [31:0] prdata_out;
  logic [23:0] pixel_data_out;
  int num_errors = 0, tests_run = 0, cyc = 0;
  dlicr_far_model u_far (.clock_in, .resetn_in, .go_in(go), .len_in(lent),
    .pclk_en_out(pclk_en_in), .active_out(cc_txn_active_in));
  // watchdog unit shortened to 4 cycles to keep the run short
  dlicr_top #(.WDOG_UNIT_CYCLES(4)) u_dut (.clock_in, .resetn_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
    .pready_out, .pslverr_out, .back_link_check_gen_en_out,
    .idle_input_pull_down_out, .pclk_en_in, .dual_lane_in, .pixel_valid_in,
    .line_sync_in, .frame_sync_in, .pixel_data_in,
    .ser_protected_in, .pixel_valid_out, .line_sync_out, .frame_sync_out,
    .pixel_data_out, .scl_in, .sda_in, .scl_clean_out,
    .sda_held_out, .i2c_txn_start_in, .i2c_addr_match_in, .i2c_write_in,
    .fwd_lock_in, .i2c_forward_out, .i2c_write_ack_out, .cc_txn_active_in,
    .cc_txn_abort_out);
  always #2 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      num_errors++;
      $display("BAD at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
    end while (pready_out !== 1'b1);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, {24'h0, x});
    chk(32'(e), 32'(xe));
  endtask
  task automatic t_regs();
    rd(8'h0c, 8'hf0, 1'b0);
    rd(8'h10, 8'hfe, 1'b0);
    rd(8'h14, 8'h1e, 1'b0);
    chk(32'(back_link_check_gen_en_out), 32'h1);
    chk(32'(idle_input_pull_down_out), 32'h1);
    wr(8'h0c, 8'h81);
    wr(8'h14, 8'h6b);
    pstrb_in <= 4'h0;
    wr(8'h0c, 8'h55);
    pstrb_in <= 4'h1;
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h00, 1'b1);
    rd(8'h0c, 8'h81, 1'b0);
    rd(8'h14, 8'h6b, 1'b0);
    chk(32'(back_link_check_gen_en_out), 32'h0);
    chk(32'(idle_input_pull_down_out), 32'h0);
  endtask
  task automatic t_steer();
    logic [4:0] i;
    for (int k = 0; k < 32; k++) begin
      i = 5'(k);
      wr(8'h0c, {4'hf, i[1], i[3], 2'b00});
      wr(8'h14, {i[0], 7'h1e});
      @(posedge clock_in);
      i2c_txn_start_in <= 1'b1;
      i2c_addr_match_in <= i[2];
      fwd_lock_in <= i[4];
      i2c_write_in <= i[0] ^ i[2];
      @(posedge clock_in);
      i2c_txn_start_in <= 1'b0;
      @(posedge clock_in);
      chk(32'(i2c_forward_out), 32'(i[0] | (i[1] & i[2])));
      chk(32'(i2c_write_ack_out), 32'((i[0] ^ i[2]) & (i[3] | i[4])));
    end
  endtask
  task automatic t_gate();
    for (int k = 0; k < 4; k++) begin
      wr(8'h0c, {6'h3c, k[0], 1'b0});
      ser_protected_in <= k[1];
      pixel_data_in <= 24'h5a_c3a5;
      repeat (4) @(posedge clock_in);
      chk(32'(pixel_data_out), k == 0 ? 32'h005a_c3a5 : 32'h0);
    end
    ser_protected_in <= 1'b0;
  endtask
  task automatic t_filt(input logic [7:0] c, input logic dl, input int w,
                        input logic x);
    logic [2:0] seen;
    seen = 3'b000;
    wr(8'h0c, c);
    dual_lane_in <= dl;
    repeat (8) @(posedge clock_in);
    {frame_sync_in, line_sync_in, pixel_valid_in} <= 3'b111;
    repeat (w) @(posedge clock_in);
    {frame_sync_in, line_sync_in, pixel_valid_in} <= 3'b000;
    repeat (24) begin
      @(posedge clock_in);
      seen = seen | {frame_sync_out, line_sync_out, pixel_valid_out};
    end
    chk(32'(seen), 32'({3{x}}));
  endtask
  task automatic t_i2c();
    logic seen;
    int n;
    seen = 1'b0;
    n = 0;
    wr(8'h14, 8'h1e);
    scl_in <= 1'b0;
    repeat (12) @(posedge clock_in);
    scl_in <= 1'b1;
    repeat (40) begin
      @(posedge clock_in);
      seen = seen | !scl_clean_out;
    end
    chk(32'(seen), 32'h0);
    {scl_in, sda_in} <= 2'b00;
    while (scl_clean_out !== 1'b0 && n < 60) begin
      @(posedge clock_in);
      n++;
    end
    chk(32'(n >= 20 && n < 60), 32'h1);
    repeat (10) @(posedge clock_in);
    chk(32'(sda_held_out), 32'h1);
    repeat (10) @(posedge clock_in);
    chk(32'(sda_held_out), 32'h0);
    {scl_in, sda_in} <= 2'b11;
    repeat (40) @(posedge clock_in);
  endtask
  task automatic t_wdog(input logic [7:0] c, input logic [7:0] len,
                        input int lo, input int hi);
    int n;
    n = 0;
    wr(8'h10, c);
    @(posedge clock_in);
    go <= 1'b1;
    lent <= len;
    @(posedge clock_in);
    go <= 1'b0;
    while (cc_txn_abort_out !== 1'b1 && n < 60) begin
      @(posedge clock_in);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
    @(posedge clock_in);
    go <= 1'b1;
    lent <= 8'h01;
    @(posedge clock_in);
    go <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask
  initial begin
    repeat (16) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_regs();
    t_steer();
    t_gate();
    t_filt(8'hf0, 1'b0, 2, 1'b0);
    t_filt(8'hf0, 1'b0, 6, 1'b1);
    t_filt(8'hf0, 1'b1, 6, 1'b0);
    t_filt(8'hf0, 1'b1, 12, 1'b1);
    t_filt(8'he2, 1'b1, 2, 1'b1);
    t_wdog(8'h06, 8'h00, 12, 16);
    t_wdog(8'h02, 8'h00, 4, 8);
    t_wdog(8'h02, 8'h03, 60, 60);
    t_wdog(8'h07, 8'h00, 60, 60);
    t_i2c();
    results();
  end
endmodule
`default_nettype wire
